//--- bench/wsc_pin_model.sv
// fault pin partner: pull-up resistor and low-pulse meter
module wsc_pin_model (
  input wire logic ref_clk,
  input wire logic oe,
  input wire logic dataOut,
  output logic pin,
  output int pulseCnt,
  output int lowLen
);
  timeunit 1ns;
  timeprecision 1ps;
  int run = 0;
  int nPulse = 0;
  int lastLen = 0;
  // pull-up brings the released pin back high
  assign pin = oe ? dataOut : 1'b1;
  assign pulseCnt = nPulse;
  assign lowLen = lastLen;
  // a pulse is counted only once it ends, so its length is final
  always @(posedge ref_clk) begin
    if (!pin) begin
      run <= run + 1;
    end else if (run != 0) begin
      nPulse <= nPulse + 1;
      lastLen <= run;
      run <= 0;
    end
  end
endmodule : wsc_pin_model

//--- bench/wsc_top_test.sv
// self-checking bench for the supervisor and clock monitor
module wsc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic oscRun = 1'b1;
  logic idleMode = 1'b0;
  logic haltMode = 1'b0;
  logic rcOscOption = 1'b0;
  logic restartDelayBit = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [3:0] oscDiv = 4'h0;
  logic pready, pslverr, pin, oe, dOut;
  logic [33:0] expQ[$];
  logic [33:0] e;
  int nErrors = 0;
  int nChecks = 0;
  int expPulses = 0;
  int pulseCnt, lowLen;
  wsc_top #(.CM_LIMIT_CYC(200)) wsc_top_i (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .oscillatorInputPin(oscDiv[1]),
    .faultOutputNIn(pin), .faultOutputNOut(dOut), .faultOutputNOe(oe), .haltMode(haltMode),
    .idleMode(idleMode), .rcOscOption(rcOscOption), .restartDelayBit(restartDelayBit));
  wsc_pin_model wsc_pin_model_i (.ref_clk(ref_clk), .oe(oe), .dataOut(dOut), .pin(pin),
    .pulseCnt(pulseCnt), .lowLen(lowLen));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // one tick every 4 cycles, the fastest the 3-flop sync can follow
  always @(posedge ref_clk) begin
    if (oscRun) begin
      oscDiv <= oscDiv + 4'h1;
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic summarize;
    $display("checks=%0d errors=%0d", nChecks, nErrors);
    if (nErrors == 0 && nChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic err, input logic [31:0] rd);
    expQ.push_back({wr, err, rd});
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // ready taken at the rising edge; request released only after it
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic ticks(input int n);
    repeat (n * 4) @(posedge ref_clk);
  endtask : ticks
  task automatic fault(input int add);
    int n;
    n = 0;
    expPulses += add;
    repeat (12) @(posedge ref_clk);
    while ((oe !== 1'b0 || pin !== 1'b1) && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (2) @(posedge ref_clk);
    cmp(pulseCnt, expPulses);
    if (add > 0) begin
      cmp(32'(lowLen >= 64 && lowLen <= 140), 32'h1);
    end
  endtask : fault
  always @(negedge ref_clk) begin
    if (psel && penable && pready === 1'b1) begin
      e = expQ.pop_front();
      cmp({31'h0, pslverr}, {31'h0, e[32]});
      if (!e[33] && !e[32]) begin
        cmp(prdata, e[31:0]);
      end
    end
  end
  initial begin
    #900000;
    nErrors++;
    summarize();
  end
  initial begin
    logic [4:0] k;
    logic [1:0] w;
    void'($urandom(32'h9b602fca));
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, 1'b0, 32'h000000c1);
    apb(1'b0, {10'($urandom_range(1, 1023)), 2'b00}, 32'h0, 1'b1, 32'h0);
    ticks(100);
    apb(1'b1, 12'h000, 32'h00000019, 1'b0, 32'h0);
    fault(0);
    ticks(2100);
    apb(1'b1, 12'h000, 32'h00000018, 1'b0, 32'h0);
    fault(0);
    apb(1'b0, 12'h000, 32'h0, 1'b0, 32'h00000001);
    apb(1'b1, 12'h000, 32'h00000019, 1'b0, 32'h0);
    repeat (4) @(posedge ref_clk);
    apb(1'b1, 12'h000, 32'h0000003f, 1'b0, 32'h0);
    fault(1);
    for (int i = 0; i < 2; i++) begin
      k = i ? 5'($urandom_range(13, 31)) : 5'h0c;
      w = i ? 2'b00 : 2'($urandom_range(1, 3));
      ticks(2100);
      apb(1'b1, 12'h000, {24'h0, w, k, 1'b1}, 1'b0, 32'h0);
      fault(1);
    end
    // auto service on idle exit makes this otherwise legal write early
    ticks(2100);
    idleMode <= 1'b1;
    ticks(10);
    idleMode <= 1'b0;
    ticks(10);
    apb(1'b1, 12'h000, 32'h00000019, 1'b0, 32'h0);
    fault(1);
    // first halt reloads, second resumes: only then is 8100 reached quietly
    ticks(3000);
    haltMode <= 1'b1;
    rcOscOption <= 1'($urandom_range(0, 1));
    restartDelayBit <= 1'b1;
    ticks(20);
    haltMode <= 1'b0;
    ticks(3000);
    haltMode <= 1'b1;
    rcOscOption <= 1'b1;
    restartDelayBit <= 1'b0;
    ticks(200);
    haltMode <= 1'b0;
    ticks(5100);
    cmp(pulseCnt, expPulses);
    cmp({31'h0, oe}, 32'h0);
    ticks(150);
    fault(1);
    oscRun <= 1'b0;
    haltMode <= 1'b1;
    repeat (150) @(posedge ref_clk);
    cmp({31'h0, oe}, 32'h0);
    repeat (150) @(posedge ref_clk);
    cmp({31'h0, oe}, 32'h1);
    oscRun <= 1'b1;
    haltMode <= 1'b0;
    repeat (300) @(posedge ref_clk);
    expPulses++;
    cmp(pulseCnt, expPulses);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, 1'b0, 32'h000000c1);
    apb(1'b1, 12'h000, {24'h0, 2'b00, 5'($urandom_range(13, 31)), 1'b0}, 1'b0, 32'h0);
    fault(1);
    apb(1'b0, 12'h000, 32'h0, 1'b0, 32'h000000c1);
    summarize();
  end
endmodule : wsc_top_test

//--- verilog/wsc_pkg.sv
// types shared by the supervisor and clock monitor
package wsc_pkg;
  typedef struct packed {
    logic [1:0] win;
    logic [4:0] key;
    logic cmEn;
  } wsc_svc_s;
  typedef enum logic [1:0] {SV_RUN, SV_PULL, SV_HOLD, SV_WAITHI} wsc_sv_e;
  typedef enum logic [1:0] {CM_OK, CM_FAULT, CM_RECOVER} wsc_cm_e;
endpackage : wsc_pkg

//--- verilog/wsc_regs.svh
// register offsets, field values and timing constants of the supervisor
`ifndef WSC_REGS_SVH
`define WSC_REGS_SVH
`define WSC_SVC_OFFSET 12'h000
`define WSC_KEY 5'h0c
`define WSC_KEY_ZERO 5'h00
`define WSC_WIN_RST 2'h3
`define WSC_CM_RST 1'h1
`define WSC_LOWER_TC 17'h00800
`define WSC_UPPER_BASE 17'h02000
`define WSC_CNT_ZERO 17'h00000
`define WSC_CNT_ONE 17'h00001
`define WSC_HOLD_LAST 6'h17
`define WSC_HOLD_ZERO 6'h00
`define WSC_HOLD_ONE 6'h01
`define WSC_CM_TIME_US 1000
`define WSC_CLK_MHZ 100
`define WSC_GAP_ZERO 32'h00000000
`define WSC_GAP_ONE 32'h00000001
`define WSC_RD_PAD 24'h000000
`define WSC_DATA_ZERO 32'h00000000
`endif

//--- verilog/wsc_top.sv
// windowed program supervisor with clock monitor behind an apb slave
//
// The implementer's own choices: the APB register port and the placing of the registers.
`include "wsc_regs.svh"

// Behaviour
// - service byte: window, key, monitor enable
// - key field must equal fixed pattern
// - lower limit fixed at 2048 cycles
// - window code picks 8k to 64k
// - reset inhibits; then max window, monitor on
// - only first good write sets choices
// - bad key on first write errors
// - later writes compared in bits 7:1
// - no service before upper limit errors
// - early service errors; many later accepted
// - first write restarts the window
// - pull pin low, hold 16-32 cycles
// - window restarts when pin goes high
// - services ignored while pin driven; code still takes them while only the monitor drives it
// - monitor drives pin while clock slow
// - 10 kHz passes, below 10 Hz flagged
// - key field reads back as zeros
// - timeout halted in halt/idle, monitor runs
// - halt exit resumes or reloads window
// - idle exit performs automatic service
// - first service may come anytime early
module wsc_top #(
  parameter int unsigned CM_LIMIT_CYC = `WSC_CM_TIME_US * `WSC_CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic oscillatorInputPin,
  input wire logic faultOutputNIn,
  output logic faultOutputNOut,
  output logic faultOutputNOe,
  input wire logic haltMode,
  input wire logic idleMode,
  input wire logic rcOscOption,
  input wire logic restartDelayBit
);

  function automatic logic isSvc(input logic [11:0] a);
    return a == `WSC_SVC_OFFSET;
  endfunction : isSvc

  function automatic logic [16:0] upperLast(input logic [1:0] w);
    return (`WSC_UPPER_BASE << w) - `WSC_CNT_ONE;
  endfunction : upperLast

  logic [1:0] pinRaw;
  logic [1:0] pinLvl;
  logic oscPrev_q;
  logic tick;
  logic pinHigh;

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic apbAccess;
  logic xfer;
  logic svcWr;
  wsc_pkg::wsc_svc_s wrVal;

  wsc_pkg::wsc_svc_s svc_q;
  logic firstDone_q;
  wsc_pkg::wsc_sv_e svState_q;
  logic [16:0] wndCnt_q;
  logic [5:0] svHold_q;
  logic haltPrev_q;
  logic idlePrev_q;
  logic counting;
  logic svcTaken;
  logic svcErr;
  logic timeoutHit;
  logic haltExit;
  logic idleExit;

  wsc_pkg::wsc_cm_e cmState_q;
  logic [31:0] gapCnt_q;
  logic [5:0] cmHold_q;
  logic clkSlow;
  logic faultOe_q;
  logic faultOut_q;

  // pins from outside: three flops, change accepted when last two agree
  assign pinRaw = {faultOutputNIn, oscillatorInputPin};

  for (genvar g = 0; g < 2; g++) begin : gSync
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        lvl_q <= 1'b0;
      end else begin
        s1_q <= pinRaw[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          lvl_q <= s3_q;
        end
      end
    end
    assign pinLvl[g] = lvl_q;
  end

  // one tick per rising edge of the instruction clock
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      oscPrev_q <= 1'b0;
    end else begin
      oscPrev_q <= pinLvl[0];
    end
  end

  assign tick = pinLvl[0] & ~oscPrev_q;
  assign pinHigh = pinLvl[1];

  // apb slave: one wait state, answer in second access cycle
  assign apbAccess = psel & penable;
  assign xfer = apbAccess & pready_q;
  assign wrVal = wsc_pkg::wsc_svc_s'(pwdata[7:0]);
  assign svcWr = xfer & pwrite & isSvc(paddr) & pstrb[0];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= apbAccess & ~pready_q;
      pslverr_q <= apbAccess & ~pready_q & ~isSvc(paddr);
    end
  end

  // key never readable, so it cannot be copied by runaway code
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_q <= `WSC_DATA_ZERO;
    end else if (apbAccess & ~pready_q & ~pwrite & isSvc(paddr)) begin
      prdata_q <= {`WSC_RD_PAD, svc_q.win, `WSC_KEY_ZERO, svc_q.cmEn};
    end else begin
      prdata_q <= `WSC_DATA_ZERO;
    end
  end

  // service check
  always_comb begin
    svcTaken = 1'b0;
    svcErr = 1'b0;
    if (svcWr && svState_q == wsc_pkg::SV_RUN) begin
      if (!firstDone_q) begin
        svcTaken = 1'b1;
        svcErr = wrVal.key != `WSC_KEY;
      end else if (wrVal.win != svc_q.win || wrVal.key != `WSC_KEY) begin
        svcErr = 1'b1;
      end else if (wndCnt_q < `WSC_LOWER_TC) begin
        svcErr = 1'b1;
      end else begin
        svcTaken = 1'b1;
      end
    end
  end

  // mismatched monitor bit is accepted; later writes cannot change it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      svc_q <= '{win: `WSC_WIN_RST, key: `WSC_KEY, cmEn: `WSC_CM_RST};
      firstDone_q <= 1'b0;
    end else if (svcWr && svState_q == wsc_pkg::SV_RUN && !firstDone_q) begin
      firstDone_q <= 1'b1;
      if (wrVal.key == `WSC_KEY) begin
        svc_q <= '{win: wrVal.win, key: `WSC_KEY, cmEn: wrVal.cmEn};
      end
    end
  end

  assign haltExit = haltPrev_q & ~haltMode;
  assign idleExit = idlePrev_q & ~idleMode;
  assign counting = svState_q == wsc_pkg::SV_RUN && !haltMode && !idleMode;
  assign timeoutHit = counting & tick & (wndCnt_q == upperLast(svc_q.win));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      haltPrev_q <= 1'b0;
      idlePrev_q <= 1'b0;
    end else begin
      haltPrev_q <= haltMode;
      idlePrev_q <= idleMode;
    end
  end

  // window counter in instruction cycles
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wndCnt_q <= `WSC_CNT_ZERO;
    end else if (svState_q == wsc_pkg::SV_WAITHI && pinHigh) begin
      wndCnt_q <= `WSC_CNT_ZERO;
    end else if (svcTaken || idleExit) begin
      wndCnt_q <= `WSC_CNT_ZERO;
    end else if (haltExit && !(rcOscOption && !restartDelayBit)) begin
      wndCnt_q <= `WSC_CNT_ZERO;
    end else if (counting && tick && !timeoutHit) begin
      wndCnt_q <= wndCnt_q + `WSC_CNT_ONE;
    end
  end

  // supervision fault sequence
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      svState_q <= wsc_pkg::SV_RUN;
      svHold_q <= `WSC_HOLD_ZERO;
    end else begin
      case (svState_q)
        wsc_pkg::SV_RUN: begin
          if (svcErr || timeoutHit) begin
            svState_q <= wsc_pkg::SV_PULL;
          end
        end
        wsc_pkg::SV_PULL: begin
          svHold_q <= `WSC_HOLD_ZERO;
          if (!pinHigh) begin
            svState_q <= wsc_pkg::SV_HOLD;
          end
        end
        wsc_pkg::SV_HOLD: begin
          if (tick) begin
            svHold_q <= svHold_q + `WSC_HOLD_ONE;
            if (svHold_q == `WSC_HOLD_LAST) begin
              svState_q <= wsc_pkg::SV_WAITHI;
            end
          end
        end
        wsc_pkg::SV_WAITHI: begin
          if (pinHigh) begin
            svState_q <= wsc_pkg::SV_RUN;
          end
        end
        default: begin
          svState_q <= wsc_pkg::SV_RUN;
        end
      endcase
    end
  end

  // clock monitor on the reference clock, so it works with no tick at all
  // threshold 1 ms lies between 100 us and 100 ms periods
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gapCnt_q <= `WSC_GAP_ZERO;
    end else if (tick) begin
      gapCnt_q <= `WSC_GAP_ZERO;
    end else if (gapCnt_q != CM_LIMIT_CYC) begin
      gapCnt_q <= gapCnt_q + `WSC_GAP_ONE;
    end
  end

  assign clkSlow = gapCnt_q == CM_LIMIT_CYC;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmState_q <= wsc_pkg::CM_OK;
      cmHold_q <= `WSC_HOLD_ZERO;
    end else if (!svc_q.cmEn) begin
      cmState_q <= wsc_pkg::CM_OK;
      cmHold_q <= `WSC_HOLD_ZERO;
    end else begin
      case (cmState_q)
        wsc_pkg::CM_OK: begin
          if (clkSlow) begin
            cmState_q <= wsc_pkg::CM_FAULT;
          end
        end
        wsc_pkg::CM_FAULT: begin
          cmHold_q <= `WSC_HOLD_ZERO;
          if (tick) begin
            cmState_q <= wsc_pkg::CM_RECOVER;
          end
        end
        wsc_pkg::CM_RECOVER: begin
          if (clkSlow) begin
            cmState_q <= wsc_pkg::CM_FAULT;
          end else if (tick) begin
            cmHold_q <= cmHold_q + `WSC_HOLD_ONE;
            if (cmHold_q == `WSC_HOLD_LAST) begin
              cmState_q <= wsc_pkg::CM_OK;
            end
          end
        end
        default: begin
          cmState_q <= wsc_pkg::CM_OK;
        end
      endcase
    end
  end

  // open-drain fault pin, data always low
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      faultOe_q <= 1'b0;
      faultOut_q <= 1'b0;
    end else begin
      faultOut_q <= 1'b0;
      faultOe_q <= (svState_q == wsc_pkg::SV_PULL) || (svState_q == wsc_pkg::SV_HOLD) ||
                   (cmState_q != wsc_pkg::CM_OK);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign faultOutputNOut = faultOut_q;
  assign faultOutputNOe = faultOe_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  AST_FIRST_BAD_KEY: assert property (
    svcWr && svState_q == wsc_pkg::SV_RUN && !firstDone_q && wrVal.key != `WSC_KEY
    |=> svState_q == wsc_pkg::SV_PULL ##1 faultOe_q)
    else $error("bad first key did not raise fault");

  AST_CHOICE_LOCK: assert property (
    firstDone_q |=> $stable(svc_q))
    else $error("window or monitor choice changed after first service");

  AST_RESET_DEFAULT: assert property (
    !firstDone_q |-> svc_q.win == `WSC_WIN_RST && svc_q.cmEn == `WSC_CM_RST)
    else $error("reset selection not maximum window with monitor on");

  AST_EARLY_SERVICE: assert property (
    svcWr && svState_q == wsc_pkg::SV_RUN && firstDone_q && wndCnt_q < `WSC_LOWER_TC
    |=> svState_q == wsc_pkg::SV_PULL)
    else $error("early service not flagged");

  AST_WINDOW_MISMATCH: assert property (
    svcWr && svState_q == wsc_pkg::SV_RUN && firstDone_q && wrVal.win != svc_q.win
    |=> svState_q == wsc_pkg::SV_PULL)
    else $error("window mismatch not flagged");

  AST_TIMEOUT: assert property (
    counting && tick && wndCnt_q == upperLast(svc_q.win) && !svcWr
    |=> svState_q == wsc_pkg::SV_PULL ##1 faultOe_q)
    else $error("window expiry not flagged");

  AST_IGNORE_WHILE_LOW: assert property (
    svcWr && svState_q != wsc_pkg::SV_RUN && !(svState_q == wsc_pkg::SV_WAITHI && pinHigh)
    |=> $stable(firstDone_q) && svState_q != wsc_pkg::SV_RUN)
    else $error("service taken while fault active");

  AST_RESTART_ON_HIGH: assert property (
    svState_q == wsc_pkg::SV_WAITHI && pinHigh |=> wndCnt_q == `WSC_CNT_ZERO)
    else $error("window not restarted on pin release");

  AST_KEY_HIDDEN: assert property (
    pready_q |-> prdata_q[5:1] == `WSC_KEY_ZERO)
    else $error("key visible on read");

  AST_HALT_FREEZE: assert property (
    haltMode && $past(haltMode) && svState_q == wsc_pkg::SV_RUN &&
    $past(svState_q) == wsc_pkg::SV_RUN && !$past(svcTaken) && !$past(idleExit)
    |-> $stable(wndCnt_q))
    else $error("window counted during halt");

  AST_IDLE_SERVICE: assert property (
    idleExit && svState_q == wsc_pkg::SV_RUN |=> wndCnt_q == `WSC_CNT_ZERO)
    else $error("idle exit did not restart window");

  AST_CLOCK_SLOW: assert property (
    svc_q.cmEn && clkSlow && cmState_q == wsc_pkg::CM_OK |=> ##1 faultOe_q)
    else $error("slow clock did not drive fault pin");

  COV_GOOD_SERVICE: cover property (svcTaken && firstDone_q);
  COV_TIMEOUT: cover property (timeoutHit);
  COV_FAULT_RELEASE: cover property (svState_q == wsc_pkg::SV_WAITHI ##1 !faultOe_q);
  COV_CLOCK_FAULT: cover property (cmState_q == wsc_pkg::CM_FAULT);

endmodule : wsc_top
